//--- logic/elc_led_ctrl.sv
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "elc_params.svh"

module elc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;
  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be power of 2");
  assign inReady  = (count_ff != (AW+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData  = mem[rdPtr_ff];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_ff] <= inData;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      wrPtr_ff <= wrPtr_ff + AW'(push);
      rdPtr_ff <= rdPtr_ff + AW'(pop);
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module elc_led_ctrl #(
  parameter int CLK_HZ   = `ELC_CLK_HZ,
  parameter int STEP_CYC = 500,
  parameter int SER_DIV  = 4
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        pulseEnIn,
  input  wire logic [15:0] ledStateIn,
  input  wire logic [3:0]  ledNorm0In,
  input  wire logic [3:0]  ledNorm1In,
  output logic [3:0]       ledPort0,
  output logic [3:0]       ledPort1,
  output logic             ledPulse,
  output logic             ledSwap,
  output logic             frameDrop
);
  import elc_pkg::*;

  if (STEP_CYC < 1 || STEP_CYC > 65536 || SER_DIV < 2 || SER_DIV > 256 ||
      CLK_HZ < 2 * `ELC_HZ_0 * 32) $error("parameter out of range");
  localparam int FRAME_DIV [8] = '{
    CLK_HZ / `ELC_HZ_0, CLK_HZ / `ELC_HZ_1, CLK_HZ / `ELC_HZ_2,
    CLK_HZ / `ELC_HZ_3, CLK_HZ / `ELC_HZ_4, CLK_HZ / `ELC_HZ_5,
    CLK_HZ / `ELC_HZ_6, CLK_HZ / `ELC_HZ_0};
  function automatic logic [31:0] frameDiv(input logic [2:0] r);
    frameDiv = 32'(FRAME_DIV[r]);
  endfunction
  // leds sent per phy: 4,3,2,1
  function automatic logic [2:0] ledsPerPhy(input logic [1:0] s);
    ledsPerPhy = 3'h4 - {1'b0, s};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus: one wait state, then the answer
  elc_ctrl_t   ctrl_ff;
  logic        ack_ff;
  logic        hit;
  logic [15:0] ctrlBits;
  assign hit         = (address == `ELC_REG_ADDR);
  assign waitrequest = (read | write) & ~ack_ff;
  assign ctrlBits    = ctrl_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (read | write) & ~ack_ff;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      readdata <= '0;
    end else if (read & ~ack_ff) begin
      readdata <= hit ? {16'h0000, ctrlBits} : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `ELC_CTRL_RST;
    end else if (write & ack_ff & hit) begin
      if (byteenable[1]) begin
        ctrl_ff.duty <= writedata[`ELC_DUTY_HI:`ELC_DUTY_LO];
      end
      if (byteenable[0]) begin
        ctrl_ff.p1En <= writedata[`ELC_P1EN_BIT];
        ctrl_ff.p0En <= writedata[`ELC_P0EN_BIT];
        ctrl_ff.rate <= writedata[`ELC_RATE_HI:`ELC_RATE_LO];
        ctrl_ff.sel  <= writedata[`ELC_SEL_HI:`ELC_SEL_LO];
        ctrl_ff.swap <= writedata[`ELC_SWAP_BIT];
      end
    end
  end

  assign ledSwap = ctrl_ff.swap;

  ////////////////////////////////////////////////////////////////////////////
  // pulse generator; settings above 198 are held at 198
  logic [15:0] stepCnt_ff;
  logic [7:0]  pwmStep_ff;
  logic [7:0]  dutyEff;
  logic        pwmHigh;
  assign dutyEff = (ctrl_ff.duty > `ELC_DUTY_MAX) ? `ELC_DUTY_MAX
                                                  : ctrl_ff.duty;
  assign pwmHigh = (pwmStep_ff <= dutyEff);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stepCnt_ff <= '0;
      pwmStep_ff <= '0;
    end else if (stepCnt_ff == 16'(STEP_CYC - 1)) begin
      stepCnt_ff <= '0;
      pwmStep_ff <= (pwmStep_ff == `ELC_DUTY_STEPS - 8'h01) ? 8'h00
                                                            : pwmStep_ff + 8'h01;
    end else begin
      stepCnt_ff <= stepCnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ledPulse <= 1'b1;
    end else begin
      ledPulse <= pulseEnIn ? pwmHigh : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame timer; basic stream runs at the fastest frame rate
  logic [31:0] frameCnt_ff;
  logic        frameTick;
  logic        basic;
  logic        pend_ff;
  assign basic     = (ctrl_ff.rate == `ELC_RATE_BASIC);
  assign frameTick = (frameCnt_ff >= frameDiv(ctrl_ff.rate) - 32'h1);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frameCnt_ff <= '0;
    end else begin
      frameCnt_ff <= frameTick ? 32'h0 : frameCnt_ff + 32'h1;
    end
  end
  // a snapshot waits for fifo room; a tick while still waiting is dropped
  logic        fifoInReady;
  logic [15:0] fifoData;
  logic        fifoValid;
  logic        fifoPop;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_ff   <= 1'b0;
      frameDrop <= 1'b0;
    end else begin
      pend_ff   <= frameTick | (pend_ff & ~fifoInReady);
      frameDrop <= frameTick & pend_ff & ~fifoInReady;
    end
  end

  elc_fifo #(.WIDTH(16), .DEPTH(32)) uFifo (
    .clk      (ref_clk),
    .rst      (rst),
    .inData   (ledStateIn),
    .inValid  (pend_ff),
    .inReady  (fifoInReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // serialiser: word holds phy n leds at bits 4n+3..4n
  elc_state_t  state_ff;
  logic [15:0] word_ff;
  logic [4:0]  bitIdx_ff;
  logic [4:0]  bitTotal_ff;
  logic [2:0]  perPhy_ff;
  logic [7:0]  divCnt_ff;
  logic        divEnd;
  elc_ser_t    ser_ff;
  assign divEnd  = (divCnt_ff == 8'(SER_DIV - 1));
  assign fifoPop = (state_ff == SER_IDLE) & fifoValid;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      divCnt_ff <= '0;
    end else begin
      divCnt_ff <= (divEnd || state_ff == SER_IDLE) ? 8'h00
                                                    : divCnt_ff + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff    <= SER_IDLE;
      word_ff     <= '0;
      bitIdx_ff   <= '0;
      bitTotal_ff <= '0;
      perPhy_ff   <= 3'h4;
    end else begin
      unique case (state_ff)
        SER_IDLE: begin
          if (fifoValid) begin
            word_ff     <= fifoData;
            bitIdx_ff   <= '0;
            perPhy_ff   <= basic ? 3'h4 : ledsPerPhy(ctrl_ff.sel);
            bitTotal_ff <= basic ? 5'h10
                                 : {ledsPerPhy(ctrl_ff.sel), 2'b00};
            state_ff    <= SER_SHIFT;
          end
        end
        SER_SHIFT: begin
          if (divEnd) begin
            if (bitIdx_ff == bitTotal_ff - 5'h01) begin
              state_ff <= SER_LATCH;
            end
            bitIdx_ff <= bitIdx_ff + 5'h01;
          end
        end
        SER_LATCH: begin
          if (divEnd) begin
            state_ff <= SER_IDLE;
          end
        end
      endcase
    end
  end

  // bit k of the frame is phy k/perPhy, led k%perPhy
  logic [4:0] phyN;
  logic [4:0] ledN;
  always_comb begin
    phyN = bitIdx_ff / {2'b00, perPhy_ff};
    ledN = bitIdx_ff - 5'(phyN * {2'b00, perPhy_ff});
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ser_ff <= '0;
    end else begin
      ser_ff.data <= (state_ff == SER_SHIFT)
                   & word_ff[4'({phyN[1:0], 2'b00} + ledN[1:0])];
      ser_ff.clk  <= (state_ff == SER_SHIFT) & (divCnt_ff >= 8'(SER_DIV / 2));
      ser_ff.load <= (state_ff == SER_LATCH);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin mux: serial pins are data, clock, load, pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ledPort0 <= '0;
      ledPort1 <= '0;
    end else begin
      ledPort0 <= ctrl_ff.p0En ? {ledPulse, ser_ff.load, ser_ff.clk, ser_ff.data}
                               : ledNorm0In;
      ledPort1 <= ctrl_ff.p1En ? {ledPulse, ser_ff.load, ser_ff.clk, ser_ff.data}
                               : ledNorm1In;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  pulse_gate_a: assert property (!pulseEnIn |=> ledPulse)
    else $error("pulse active while pulsing disabled");
  duty_min_a: assert property (pwmStep_ff == 8'h00 |-> pwmHigh)
    else $error("duty below 0.5 percent");
  duty_max_a: assert property (pwmStep_ff == 8'hC7 |-> !pwmHigh)
    else $error("duty above 99.5 percent");
  port1_mux_a: assert property (ctrl_ff.p1En && $stable(ctrl_ff.p1En)
    |=> ledPort1[0] == $past(ser_ff.data))
    else $error("port 1 pins not serial");
  port0_norm_a: assert property (!ctrl_ff.p0En
    |=> ledPort0 == $past(ledNorm0In))
    else $error("port 0 pins not normal");
  frame_len_a: assert property (frameTick && $stable(ctrl_ff.rate)
    && !$past(frameTick) |-> frameCnt_ff == frameDiv(ctrl_ff.rate) - 32'h1)
    else $error("frame period wrong");
  basic_len_a: assert property (state_ff == SER_IDLE && fifoValid
    && basic |=> bitTotal_ff == 5'h10)
    else $error("basic stream not full width");
  select_len_a: assert property (state_ff == SER_IDLE && fifoValid
    && !basic && ctrl_ff.sel == 2'b11 |=> bitTotal_ff == 5'h04)
    else $error("led select count wrong");
  swap_store_a: assert property (write && ack_ff && hit && byteenable[0]
    |=> ledSwap == $past(writedata[0]))
    else $error("swap bit not stored");
  bus_wait_a: assert property ((read || write) && !ack_ff |-> waitrequest ##1 !waitrequest)
    else $error("bus answer timing wrong");

  frame_sent_c: cover property (state_ff == SER_LATCH ##1 state_ff == SER_IDLE);
  drop_seen_c:  cover property (frameDrop);
  both_port_c:  cover property (ctrl_ff.p0En && ctrl_ff.p1En && ser_ff.load);
endmodule
`default_nettype wire

//--- logic/elc_params.svh
`ifndef ELC_PARAMS_SVH
`define ELC_PARAMS_SVH
// register index as printed; byte address is four times it
`define ELC_REG_IDX     8'h19
`define ELC_REG_ADDR    8'h64
`define ELC_REG_W       16
// field positions
`define ELC_DUTY_HI     15
`define ELC_DUTY_LO     8
`define ELC_P1EN_BIT    7
`define ELC_P0EN_BIT    6
`define ELC_RATE_HI     5
`define ELC_RATE_LO     3
`define ELC_SEL_HI      2
`define ELC_SEL_LO      1
`define ELC_SWAP_BIT    0
`define ELC_CTRL_RST    16'h0000
// pulse duty: 200 half-percent steps, highest legal setting 198
`define ELC_DUTY_STEPS  8'hC8
`define ELC_DUTY_MAX    8'hC6
// frame rates in Hz
`define ELC_HZ_0        2500
`define ELC_HZ_1        1000
`define ELC_HZ_2        500
`define ELC_HZ_3        250
`define ELC_HZ_4        200
`define ELC_HZ_5        125
`define ELC_HZ_6        40
`define ELC_RATE_BASIC  3'h7
`define ELC_CLK_HZ      100000000
`endif

//--- logic/elc_pkg.sv
package elc_pkg;
  typedef struct packed {
    logic [7:0] duty;
    logic       p1En;
    logic       p0En;
    logic [2:0] rate;
    logic [1:0] sel;
    logic       swap;
  } elc_ctrl_t;

  typedef struct packed {
    logic data;
    logic clk;
    logic load;
  } elc_ser_t;

  typedef enum logic [1:0] {SER_IDLE, SER_SHIFT, SER_LATCH} elc_state_t;
endpackage

//--- sim/elc_led_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "elc_params.svh"
module elc_led_ctrl_tb_top;
  import elc_pkg::*;
  localparam int CLKHZ = 200_000;
  logic        ref_clk    = 1'b0;
  logic        rst        = 1'b1;
  logic [7:0]  address    = 8'h00;
  logic        read       = 1'b0;
  logic        write      = 1'b0;
  logic [3:0]  byteenable = 4'h0;
  logic [31:0] writedata  = 32'h0000_0000;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        pulseEnIn  = 1'b0;
  logic [15:0] ledStateIn = 16'h0000;
  logic [3:0]  ledNorm0In = 4'h0;
  logic [3:0]  ledNorm1In = 4'h0;
  logic [3:0]  ledPort0, ledPort1;
  logic        ledPulse, ledSwap, frameSeen, frameDrop;
  int          rxBits, rxOnes;
  int          errTotal = 0;
  int          dropCnt  = 0;
  int          compares = 0;
  int          seed     = 79;
  int          cyc      = 0;
  logic [15:0] mirror   = `ELC_CTRL_RST;
  logic [31:0] expQ[$];
  int          hz[8] = '{`ELC_HZ_0, `ELC_HZ_1, `ELC_HZ_2, `ELC_HZ_3,
                         `ELC_HZ_4, `ELC_HZ_5, `ELC_HZ_6, `ELC_HZ_0};

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  elc_led_ctrl #(.CLK_HZ(CLKHZ), .STEP_CYC(2), .SER_DIV(4)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .pulseEnIn(pulseEnIn),
    .ledStateIn(ledStateIn), .ledNorm0In(ledNorm0In),
    .ledNorm1In(ledNorm1In), .ledPort0(ledPort0), .ledPort1(ledPort1),
    .ledPulse(ledPulse), .ledSwap(ledSwap), .frameDrop(frameDrop));

  elc_led_rx rx_u (.ref_clk(ref_clk), .pins(ledPort0),
    .frameSeen(frameSeen), .rxBits(rxBits), .rxOnes(rxOnes));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", compares, errTotal);
    if (errTotal == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    if (a == `ELC_REG_ADDR && be[0]) mirror[7:0] = d[7:0];
    if (a == `ELC_REG_ADDR && be[1]) mirror[15:8] = d[15:8];
    bus(1'b1, a, d, be);
  endtask

  task automatic rd(input logic [7:0] a);
    expQ.push_back(a == `ELC_REG_ADDR ? {16'h0000, mirror} : 32'h0000_0000);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
  endtask

  // the oldest note is taken whenever read data are handed over
  always @(posedge ref_clk)
    if (read === 1'b1 && waitrequest === 1'b0)
      check(readdata, expQ.pop_front());

  // the serialiser outruns every frame rate, so no snapshot may be lost
  always @(posedge ref_clk)
    if (rst === 1'b0 && frameDrop !== 1'b0) dropCnt++;

  task automatic waitFrame;
    do @(posedge ref_clk); while (frameSeen !== 1'b1);
  endtask

  function automatic int expOnes(input logic [15:0] s, input int k);
    int n = 0;
    for (int p = 0; p < 4; p++)
      for (int m = 0; m < k; m++)
        n += s[4*p+m];
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100_000) @(posedge ref_clk);
    errTotal++;
    tally_and_finish();
  end

  initial begin
    int t0, n, k;
    logic [7:0] d[3];
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    ledNorm0In <= $random(seed);
    ledNorm1In <= $random(seed);
    rd(`ELC_REG_ADDR);
    for (int i = 0; i < 4; i++) begin
      wr(`ELC_REG_ADDR, $random(seed), 4'hF);
      rd(`ELC_REG_ADDR);
      repeat (3) @(posedge ref_clk);
      check(ledSwap, mirror[0]);
    end
    wr(`ELC_REG_ADDR, $random(seed), 4'b0010);
    rd(`ELC_REG_ADDR);
    wr(8'h60, 32'hFFFF_FFFF, 4'hF);
    rd(8'h60);
    rd(`ELC_REG_ADDR);
    wr(`ELC_REG_ADDR, 32'h0000_0040, 4'hF);
    repeat (3) @(posedge ref_clk);
    check(ledPort1, ledNorm1In);
    wr(`ELC_REG_ADDR, 32'h0000_0080, 4'hF);
    repeat (3) @(posedge ref_clk);
    check(ledPort0, ledNorm0In);
    $display("register test done");

    d[0] = 8'h00;
    d[1] = `ELC_DUTY_MAX;
    d[2] = 8'($unsigned($random(seed)) % 199);
    for (int i = 0; i < 3; i++) begin
      wr(`ELC_REG_ADDR, {16'h0000, d[i], 8'h00}, 4'hF);
      pulseEnIn <= 1'b1;
      repeat (400) @(posedge ref_clk);
      n = 0;
      repeat (400) begin
        @(posedge ref_clk);
        n += (ledPulse === 1'b1);
      end
      check(n, (d[i] + 1) * 2);
    end
    pulseEnIn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    n = 0;
    repeat (400) begin
      @(posedge ref_clk);
      n += (ledPulse === 1'b1);
    end
    check(n, 400);
    $display("pulse test done");

    // stale snapshots from the old setting are let through first
    for (int r = 0; r < 8; r++) begin
      ledStateIn <= $random(seed);
      wr(`ELC_REG_ADDR, {24'h0, 2'b11, r[2:0], r[1:0], 1'b0}, 4'hF);
      waitFrame();
      waitFrame();
      t0 = cyc;
      waitFrame();
      k = (r == 7) ? 4 : 4 - (r % 4);
      check(ledPort1, ledPort0);
      check(cyc - t0, CLKHZ / hz[r]);
      check(rxBits, 4 * k);
      check(rxOnes, expOnes(ledStateIn, k));
    end
    check(dropCnt, 0);
    $display("serial test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- sim/elc_led_rx.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// serial LED sink on the port 0 pins: counts bits and lit bits per frame
module elc_led_rx (
  input  wire logic       ref_clk,
  input  wire logic [3:0] pins,
  output logic            frameSeen,
  output int              rxBits,
  output int              rxOnes
);
  logic clkQ = 1'b0;
  logic ldQ  = 1'b0;
  int   bitCnt = 0;
  int   oneCnt = 0;
  initial frameSeen = 1'b0;
  // a real shift register clocks data on the serial clock rising edge
  always @(posedge ref_clk) begin
    frameSeen <= 1'b0;
    clkQ <= pins[1];
    ldQ <= pins[2];
    if (pins[1] === 1'b1 && clkQ === 1'b0) begin
      bitCnt = bitCnt + 1;
      oneCnt = oneCnt + (pins[0] === 1'b1);
    end
    if (pins[2] === 1'b1 && ldQ === 1'b0) begin
      frameSeen <= 1'b1;
      rxBits <= bitCnt;
      rxOnes <= oneCnt;
      bitCnt = 0;
      oneCnt = 0;
    end
  end
endmodule
`default_nettype wire
